// *** hdl/recs_pkg.sv ***
// constants and carrier types for the receiver error and status buffer control bank
// Summary of operation
// (RULE1) each error enable bit gates the same-position bit of the error flags register
// (RULE2) enabled error shows in flags, on the error pin and in the interrupt request
// (RULE3) enabled error acts on current sample: hold previous or replace, per hold setting
// (RULE4) disabled error stays out of flags, pin, interrupt and sample handling
// (RULE5) subcode and channel-status checksum errors never alter the audio sample
// (RULE6) error enable register resets to all zeros
// (RULE7) buffer select 0 maps buffer space to channel status, 1 to user data
// (RULE8) protect 0 lets D-to-E overwrite first 5 status bytes, 1 preserves them
// (RULE9) D-to-E inhibit 1 blocks channel-status D-to-E transfers, 0 allows them
// (RULE10) channel select picks A or B status for flag pin, summary and one-byte reads
// (RULE11) enabled errors latch high; a flags read clears them unless source still active
package recs_pkg;
    localparam logic [6:0] ADDR_CS_SUMMARY = 7'h0f;
    localparam logic [6:0] ADDR_ERR_FLAGS = 7'h10;
    localparam logic [6:0] ADDR_ERR_ENABLES = 7'h11;
    localparam logic [6:0] ADDR_BUF_CTRL = 7'h12;
    localparam logic [7:0] ERR_ENABLES_RST = 8'h00;
    localparam logic [7:0] BUF_CTRL_RST = 8'h00;
    localparam logic [7:0] ERR_VALID_MASK = 8'h7f;
    // errors that may touch the sample: all but the two checksum errors
    localparam logic [7:0] ERR_SAMPLE_MASK = 8'h1f;
    localparam logic [7:0] BUF_CTRL_VALID_MASK = 8'h3f;
    localparam int PROTECT_BYTES = 5;
    localparam int SUM_FILTER_FLAG_BIT = 0;

    // field order follows the control register layout, bit 7 first
    typedef struct packed {
        logic [1:0]  reserved;
        logic        buffer_select;
        logic        first_bytes_protect;
        logic        status_d_to_e_inhibit;
        logic        status_e_to_f_inhibit;
        logic        buffer_port_access_width;
        logic        channel_select;
    } recs_ctrl_t;

    typedef struct packed {
        logic       sample_hold;
        logic       sample_replace;
    } recs_sample_t;
endpackage

// *** hdl/recs_err_latch.sv ***
// sticky error flag bits with read-clear
`timescale 1ns/1ps
`default_nettype none
module recs_err_latch #(
    parameter int WIDTH = 8
) (
    // clock and reset
    input wire logic i_mclk,
    input wire logic i_rst,
    // events
    input wire logic [WIDTH-1:0] i_src,
    input wire logic [WIDTH-1:0] i_enable,
    input wire logic i_rd_clear,
    // state
    output logic [WIDTH-1:0] o_flags
);
    if (WIDTH < 1)
    begin : g_bad_width
        $error("width must be positive");
    end

    logic [WIDTH-1:0] flags_ff;
    wire logic [WIDTH-1:0] gated_src = i_src & i_enable; // RULE1
    genvar g;
    generate
        for (g = 0; g < WIDTH; g++)
        begin : g_bit
            always_ff @(posedge i_mclk)
            begin
                if (i_rst)
                    flags_ff[g] <= 1'b0;
                else if (gated_src[g]) // RULE11
                    flags_ff[g] <= 1'b1;
                else if (i_rd_clear || !i_enable[g]) // RULE4
                    flags_ff[g] <= 1'b0;
            end
        end
    endgenerate
    assign o_flags = flags_ff;
endmodule
`default_nettype wire

// *** hdl/recs_sync.sv ***
// two-stage synchroniser for external error sources
`timescale 1ns/1ps
`default_nettype none
module recs_sync #(
    parameter int WIDTH = 8
) (
    // clock and reset
    input wire logic i_mclk,
    input wire logic i_rst,
    // data
    input wire logic [WIDTH-1:0] i_async,
    output logic [WIDTH-1:0] o_sync
);
    logic [WIDTH-1:0] meta_ff;
    logic [WIDTH-1:0] sync_ff;
    always_ff @(posedge i_mclk)
    begin
        if (i_rst)
        begin
            meta_ff <= '0;
            sync_ff <= '0;
        end
        else
        begin
            meta_ff <= i_async;
            sync_ff <= meta_ff;
        end
    end
    assign o_sync = sync_ff;
endmodule
`default_nettype wire

// *** hdl/recs_top.sv ***
// receiver error enables, error flags and channel-status buffer control bank
`timescale 1ns/1ps
`default_nettype none
module recs_top #(
    parameter int ADDR_W = 7,
    parameter int DATA_W = 8
) (
    // clock and reset
    input wire logic i_mclk,
    input wire logic i_rst,
    // control port register access
    input wire logic i_wr,
    input wire logic i_rd,
    input wire logic [ADDR_W-1:0] i_addr,
    input wire logic [DATA_W-1:0] i_wdata,
    output logic [DATA_W-1:0] o_rdata,
    // receiver error sources, level, from the receiver domain
    input wire logic [6:0] i_err_src,
    // received channel status summaries per channel
    input wire logic [DATA_W-1:0] i_cs_summary_a,
    input wire logic [DATA_W-1:0] i_cs_summary_b,
    // audio sample handling
    input wire logic i_hold_mode,
    input wire logic i_sample_strobe,
    output logic o_sample_hold,
    output logic o_sample_replace,
    // pins and interrupt
    output logic o_receiver_error_pin,
    output logic o_receiver_error_irq,
    output logic o_filter_flag_pin,
    // buffer controls to the buffer logic
    output logic o_buffer_select,
    output logic o_first_bytes_protect,
    output logic o_status_d_to_e_inhibit,
    output logic o_status_e_to_f_inhibit,
    output logic o_buffer_port_access_width,
    output logic o_channel_select,
    output logic [3:0] o_protect_count
);
    if (ADDR_W != 7)
    begin : g_bad_addr_w
        $error("address width must be 7");
    end
    if (DATA_W != 8)
    begin : g_bad_data_w
        $error("data width must be 8");
    end

    ////////////////////////////////////////////////////////////////////////////////
    // registers
    logic [7:0] enables_ff;
    logic [7:0] buf_ctrl_ff;
    logic [7:0] rdata_ff;
    recs_pkg::recs_sample_t sample_ff;
    logic [6:0] err_sync;
    logic [7:0] flags;

    wire logic sel_flags = (i_addr == recs_pkg::ADDR_ERR_FLAGS);
    wire logic sel_enables = (i_addr == recs_pkg::ADDR_ERR_ENABLES);
    wire logic sel_buf = (i_addr == recs_pkg::ADDR_BUF_CTRL);
    wire logic sel_sum = (i_addr == recs_pkg::ADDR_CS_SUMMARY);
    wire logic rd_flags = i_rd && sel_flags;

    always_ff @(posedge i_mclk)
    begin
        if (i_rst)
            enables_ff <= recs_pkg::ERR_ENABLES_RST; // RULE6
        else if (i_wr && sel_enables)
            enables_ff <= i_wdata & recs_pkg::ERR_VALID_MASK;
    end

    always_ff @(posedge i_mclk)
    begin
        if (i_rst)
            buf_ctrl_ff <= recs_pkg::BUF_CTRL_RST;
        else if (i_wr && sel_buf)
            buf_ctrl_ff <= i_wdata & recs_pkg::BUF_CTRL_VALID_MASK;
    end

    ////////////////////////////////////////////////////////////////////////////////
    // error path
    recs_sync #(
        .WIDTH(7)
    ) u_sync (
        .i_mclk(i_mclk),
        .i_rst(i_rst),
        .i_async(i_err_src),
        .o_sync(err_sync)
    );

    // flags clear on the read strobe; a set in the same cycle wins
    recs_err_latch #(
        .WIDTH(8)
    ) u_latch (
        .i_mclk(i_mclk),
        .i_rst(i_rst),
        .i_src({1'b0, err_sync}),
        .i_enable(enables_ff),
        .i_rd_clear(rd_flags),
        .o_flags(flags)
    );

    wire logic [7:0] live_err = {1'b0, err_sync} & enables_ff; // RULE2
    wire logic sample_err = |(live_err & recs_pkg::ERR_SAMPLE_MASK); // RULE3 RULE5
    wire recs_pkg::recs_ctrl_t ctrl = recs_pkg::recs_ctrl_t'(buf_ctrl_ff);
    wire logic summary_mux = ctrl.channel_select;
    wire logic [7:0] summary = summary_mux ? i_cs_summary_b : i_cs_summary_a; // RULE10

    always_ff @(posedge i_mclk)
    begin
        if (i_rst)
            sample_ff <= '0;
        else if (i_sample_strobe)
        begin
            // decision per sample from the live error level at the strobe, so an error gone before the strobe does not affect that sample
            sample_ff.sample_hold <= sample_err && i_hold_mode; // RULE3
            sample_ff.sample_replace <= sample_err && !i_hold_mode; // RULE3
        end
    end

    ////////////////////////////////////////////////////////////////////////////////
    // read data
    wire logic [7:0] rd_mux = sel_flags ? (flags & recs_pkg::ERR_VALID_MASK) :
                              sel_enables ? enables_ff :
                              sel_buf ? buf_ctrl_ff :
                              sel_sum ? summary : 8'h00;

    always_ff @(posedge i_mclk)
    begin
        if (i_rst)
            rdata_ff <= 8'h00;
        else if (i_rd)
            rdata_ff <= rd_mux;
    end

    ////////////////////////////////////////////////////////////////////////////////
    // outputs
    assign o_rdata = rdata_ff;
    assign o_receiver_error_pin = |flags; // RULE2
    assign o_receiver_error_irq = |flags; // RULE2
    assign o_sample_hold = sample_ff.sample_hold;
    assign o_sample_replace = sample_ff.sample_replace;
    assign o_filter_flag_pin = summary[recs_pkg::SUM_FILTER_FLAG_BIT]; // RULE10
    assign o_buffer_select = ctrl.buffer_select; // RULE7
    assign o_first_bytes_protect = ctrl.first_bytes_protect; // RULE8
    // protected byte count handed to the buffer transfer logic
    assign o_protect_count = ctrl.first_bytes_protect ? 4'(recs_pkg::PROTECT_BYTES) : 4'h0; // RULE8
    assign o_status_d_to_e_inhibit = ctrl.status_d_to_e_inhibit; // RULE9
    assign o_status_e_to_f_inhibit = ctrl.status_e_to_f_inhibit;
    assign o_buffer_port_access_width = ctrl.buffer_port_access_width;
    assign o_channel_select = summary_mux; // RULE10
endmodule
`default_nettype wire

// *** test/recs_host.sv ***
// host model driving single-byte control port accesses
`timescale 1ns/1ps
`default_nettype none
module recs_host (
    // control port
    input wire logic i_mclk,
    output logic o_wr,
    output logic o_rd,
    output logic [6:0] o_addr,
    output logic [7:0] o_wdata
);
    initial {o_wr, o_rd, o_addr, o_wdata} = 17'h00000;
    task automatic acc(input logic w, input logic [6:0] a, input logic [7:0] d);
        @(posedge i_mclk);
        #1;
        {o_wr, o_rd, o_addr, o_wdata} = {w, !w, a, d};
        @(posedge i_mclk);
        #1;
        // released address and data lines show inverted values so a stale sample cannot pass
        {o_wr, o_rd, o_addr, o_wdata} = {1'b0, 1'b0, ~a, ~d};
    endtask
endmodule
`default_nettype wire

// *** test/recs_top_chk.sv ***
// port assertions for the error and status buffer control bank
`timescale 1ns/1ps
`default_nettype none
module recs_top_chk (
    // watched ports
    input wire logic i_mclk,
    input wire logic i_rst,
    input wire logic i_wr,
    input wire logic i_rd,
    input wire logic [6:0] i_addr,
    input wire logic [7:0] i_wdata,
    input wire logic [6:0] i_err_src,
    input wire logic [7:0] i_cs_summary_a,
    input wire logic [7:0] i_cs_summary_b,
    input wire logic o_receiver_error_pin,
    input wire logic o_receiver_error_irq,
    input wire logic o_filter_flag_pin,
    input wire logic o_buffer_select,
    input wire logic o_first_bytes_protect,
    input wire logic o_channel_select,
    input wire logic [3:0] o_protect_count
);
    default clocking @(posedge i_mclk);
    endclocking
    default disable iff (i_rst);
    // four quiet cycles cover the synchroniser and the flag stage
    sequence s_quiet; (i_err_src == 7'h00) [*4]; endsequence
    sequence s_off; i_wr && i_addr == 7'h11 && i_wdata == 8'h00 ##1 !(i_wr && i_addr == 7'h11) [*2]; endsequence
    property p_flag; o_filter_flag_pin == (o_channel_select ? i_cs_summary_b[0] : i_cs_summary_a[0]); endproperty
    a_flag: assert property (p_flag) else $error("filter pin not from selected channel");
    property p_prot; o_protect_count == (o_first_bytes_protect ? 4'h5 : 4'h0); endproperty
    a_prot: assert property (p_prot) else $error("protect count wrong");
    property p_irq; o_receiver_error_irq == o_receiver_error_pin; endproperty
    a_irq: assert property (p_irq) else $error("irq differs from error pin");
    property p_wr; i_wr && i_addr == 7'h12 |=> o_buffer_select == $past(i_wdata[5])
        && o_channel_select == $past(i_wdata[0]); endproperty
    a_wr: assert property (p_wr) else $error("control write not taken");
    property p_keep; !(i_wr && i_addr == 7'h12) |=> $stable(o_buffer_select) && $stable(o_first_bytes_protect); endproperty
    a_keep: assert property (p_keep) else $error("control changed without write");
    property p_rst; $fell(i_rst) |-> !o_receiver_error_pin && !o_buffer_select && o_protect_count == 4'h0; endproperty
    a_rst: assert property (p_rst) else $error("reset state wrong");
    property p_off; s_off |=> !o_receiver_error_pin; endproperty
    a_off: assert property (p_off) else $error("error pin high with errors disabled");
    property p_clr; s_quiet ##0 (i_rd && i_addr == 7'h10) |=> !o_receiver_error_pin; endproperty
    a_clr: assert property (p_clr) else $error("flags not cleared by read");
    property p_set; $rose(o_receiver_error_pin) |-> $past(i_err_src, 3) != 7'h00; endproperty
    a_set: assert property (p_set) else $error("error pin rose without a source");
endmodule
bind recs_top recs_top_chk u_chk (.*);
`default_nettype wire

// *** test/recs_top_tb.sv ***
// self-checking bench for the error and status buffer control bank
`timescale 1ns/1ps
`default_nettype none
module recs_top_tb;
    logic clk = 1'b0, rst = 1'b1, hm = 1'b0, stb = 1'b0, wr, rd, sh, sr, pin, irq, bs, pr, di, ei, acw, csel, ffp;
    logic [6:0] addr, src = 7'h00;
    logic [7:0] wd, rdata, d, sa = 8'h00, sb = 8'h00;
    logic [3:0] pc;
    int err_count = 0, checks = 0;
    recs_host h (.i_mclk(clk), .o_wr(wr), .o_rd(rd), .o_addr(addr), .o_wdata(wd));
    recs_top DUT (.i_mclk(clk), .i_rst(rst), .i_wr(wr), .i_rd(rd), .i_addr(addr), .i_wdata(wd),
        .o_rdata(rdata), .i_err_src(src), .i_cs_summary_a(sa), .i_cs_summary_b(sb), .i_hold_mode(hm),
        .i_sample_strobe(stb), .o_sample_hold(sh), .o_sample_replace(sr), .o_receiver_error_pin(pin),
        .o_receiver_error_irq(irq), .o_filter_flag_pin(ffp), .o_buffer_select(bs), .o_first_bytes_protect(pr),
        .o_status_d_to_e_inhibit(di), .o_status_e_to_f_inhibit(ei), .o_buffer_port_access_width(acw),
        .o_channel_select(csel), .o_protect_count(pc));
    initial forever #5 clk = ~clk;
    ////////////////////////////////////////////////////////////
    task automatic stop_test;
        $display("checks %0d mismatches %0d", checks, err_count);
        if (err_count == 0 && checks > 0)
            $display("Simulation passed");
        else
            $display("Simulation failed");
        $finish;
    endtask
    task automatic chk(input logic [7:0] got, input logic [7:0] exp);
        checks++;
        if (got !== exp)
        begin
            err_count++;
            $display("unexpected at %0t: got %h expected %h", $time, got, exp);
        end
    endtask
    // read data is sampled a cycle late; it stands until the next read
    task automatic rd_chk(input logic [6:0] a, input logic [7:0] e);
        h.acc(1'b0, a, 8'h00);
        @(posedge clk);
        #1;
        chk(rdata, e);
    endtask
    task automatic wait_pin;
        for (int k = 0; k < 10 && pin !== 1'b1; k++)
        begin
            @(posedge clk);
            #1;
        end
        if (pin !== 1'b1)
        begin
            err_count++;
            $display("unexpected at %0t: error pin never rose", $time);
            stop_test;
        end
    endtask
    ////////////////////////////////////////////////////////////
    initial
    begin
        d = $urandom(32'h531b);
        repeat (10) @(posedge clk);
        #1;
        rst = 1'b0;
        for (int k = 16; k < 20; k++)
            rd_chk(k[6:0], 8'h00);
        $display("test reset done");
        for (int k = 0; k < 8; k++)
        begin
            d = (k == 0) ? 8'hff : $urandom;
            sa = $urandom;
            sb = $urandom;
            h.acc(1'b1, 7'h12, d);
            chk({2'b00, bs, pr, di, ei, acw, csel}, d & 8'h3f);
            chk({4'h0, pc}, d[4] ? 8'h05 : 8'h00);
            rd_chk(7'h12, d & 8'h3f);
            rd_chk(7'h0f, d[0] ? sb : sa);
            chk({7'h00, ffp}, {7'h00, d[0] ? sb[0] : sa[0]});
            h.acc(1'b1, 7'h11, d);
            rd_chk(7'h11, d & 8'h7f);
        end
        $display("test control done");
        // mid-run reset must bring both written registers back to zero
        rst = 1'b1;
        repeat (2) @(posedge clk);
        #1;
        rst = 1'b0;
        rd_chk(7'h11, 8'h00);
        rd_chk(7'h12, 8'h00);
        $display("test mid reset done");
        for (int i = 0; i < 7; i++)
        begin
            hm = $urandom;
            h.acc(1'b1, 7'h11, 8'h01 << i);
            src = (7'h01 << i) | (7'h01 << ((i + 1) % 7));
            wait_pin;
            chk({6'h00, pin, irq}, 8'h03);
            stb = 1'b1;
            @(posedge clk);
            #1;
            stb = 1'b0;
            chk({6'h00, sh, sr}, (i < 5) ? {6'h00, hm, !hm} : 8'h00);
            // a read while the source is still active must leave the flag set
            rd_chk(7'h10, 8'h01 << i);
            chk({7'h00, pin}, 8'h01);
            src = 7'h00;
            repeat (4) @(posedge clk);
            rd_chk(7'h10, 8'h01 << i);
            rd_chk(7'h10, 8'h00);
        end
        h.acc(1'b1, 7'h11, 8'h00);
        rd_chk(7'h11, 8'h00);
        $display("test errors done");
        stop_test;
    end
endmodule
`default_nettype wire
